// File: inc/lec_cfg.svh
/*
 * constants of the link enhancement control register and the asynchronous
 * transmit start logic: offsets, masks, reset value, thresholds.
 * assumes it is included by bare name; the guard lets it be included more than once per unit.
 */
`ifndef LEC_CFG_SVH
`define LEC_CFG_SVH

// register offsets: set and clear in memory space, alias in config space
`define LEC_OFS_SET 12'ha88
`define LEC_OFS_CLR 12'ha8c
`define LEC_OFS_CFG 12'h0f4

// writable bits 15, 13-12, 10; every other bit reads zero
`define LEC_WR_MASK 32'h0000_b400
`define LEC_RESET 32'h0000_1000
`define LEC_ZERO 32'h0000_0000
`define LEC_PIPE_BIT 15
`define LEC_THR_HI 13
`define LEC_THR_LO 12
`define LEC_MPEG_BIT 10

// threshold codes
`define THR_SNF 2'h0
`define THR_1K7 2'h1
`define THR_1K 2'h2
`define THR_512 2'h3

// thresholds in bytes and in quadlets
`define AT_BYTES_2K 2048
`define AT_BYTES_1K7 1740
`define AT_BYTES_1K 1024
`define AT_BYTES_512 512
`define AT_QUAD_2K 10'(`AT_BYTES_2K / 4)
`define AT_QUAD_1K7 10'(`AT_BYTES_1K7 / 4)
`define AT_QUAD_1K 10'(`AT_BYTES_1K / 4)
`define AT_QUAD_512 10'(`AT_BYTES_512 / 4)

// stream format code of mpeg cip streams
`define MPEG_FMT 8'h20

// one quadlet step of the fill and token counters
`define FILL_ONE 10'h001
`define FILL_ZERO 10'h000
`define EOP_ONE 8'h01
`define EOP_ZERO 8'h00

`endif

// File: inc/lec_pkg.sv
/*
 * types of the asynchronous transmit start controller.
 * assumes lec_cfg.svh for the numbers; this package holds types only.
 */
package lec_pkg;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND,
        TX_DRAIN
    } tx_state_t;

    // whole state of the controller
    typedef struct packed {
        logic [31:0] lec;
        tx_state_t st;
        logic snf_retry;
        logic [9:0] fill;
        logic [7:0] eop_pend;
        logic rd_wait;
        logic rd_req;
        logic push;
        logic [33:0] push_data;
        logic [31:0] rdata;
        logic mpeg_apply;
        logic underrun;
    } ctl_t;

endpackage : lec_pkg

// File: inc/tx_buf_if.sv
/*
 * carrier between the transmit controller and its two-entry buffer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface tx_buf_if #(
    parameter int W = 34
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport producer (
        output in_valid,
        output in_data,
        output out_ready,
        input in_ready,
        input out_valid,
        input out_data
    );
    modport buffer (
        input in_valid,
        input in_data,
        input out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );
endinterface : tx_buf_if

// File: src/tx_skid_buf.sv
/*
 * two-entry buffer with valid and ready on both sides; all outputs
 * come from flip-flops.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module tx_skid_buf #(
    parameter int W = 34
) (
    input wire logic core_clk,
    input wire logic rst_n,
    tx_buf_if.buffer bus
);
    typedef struct packed {
        logic [1:0][W-1:0] slot;
        logic [1:0] cnt;
        logic in_ready;
        logic out_valid;
    } buf_t;

    buf_t s_r;
    buf_t s_nxt;
    logic push;
    logic pop;

    if (W < 1) begin : g_chk
        $error("tx_skid_buf: width must be at least one");
    end

    // shift on pop, write behind the last entry on push
    always_comb begin
        push = bus.in_valid && s_r.in_ready;
        pop = s_r.out_valid && bus.out_ready;
        s_nxt = s_r;
        if (pop) begin
            s_nxt.slot[0] = s_r.slot[1];
        end
        s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
        if (push) begin
            s_nxt.slot[s_r.cnt[0] ^ pop] = bus.in_data;
        end
        s_nxt.in_ready = (s_nxt.cnt != 2'h2);
        s_nxt.out_valid = (s_nxt.cnt != 2'h0);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.in_ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.in_ready = s_r.in_ready;
    assign bus.out_valid = s_r.out_valid;
    assign bus.out_data = s_r.slot[0];
endmodule : tx_skid_buf

// File: src/at_tx_ctrl.sv
/*
 * link enhancement control fields and the asynchronous transmit start
 * controller: threshold or store-and-forward start, underrun fallback,
 * pipelining disable and mpeg timestamp enable outputs.
 * assumes an external transmit fifo that answers a read request with
 * data exactly one cycle later, and a link that takes words on
 * link_valid and link_ready.
 */
`timescale 1ns/10ps
`include "lec_cfg.svh"

module at_tx_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic soft_rst_n,
    input wire logic reg_cfg_space,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic retry_count_zero,
    input wire logic [7:0] stream_format_code,
    input wire logic fifo_wr_quad,
    input wire logic fifo_wr_eop,
    output logic fifo_rd_req,
    input wire logic fifo_rd_valid,
    input wire logic [31:0] fifo_rd_data,
    input wire logic fifo_rd_eop,
    output logic link_valid,
    input wire logic link_ready,
    output logic [31:0] link_data,
    output logic link_eop,
    output logic link_err,
    output logic at_underrun,
    output logic async_tx_pipeline_disable,
    output logic mpeg_timestamp_enable,
    output logic mpeg_ts_apply
);
    lec_pkg::ctl_t s_r;
    lec_pkg::ctl_t s_nxt;
    logic [31:0] wmask;
    logic [9:0] thr_quads;
    logic snf;
    logic start;
    logic can_req;
    logic hit_set;
    logic hit_clr;
    logic hit_cfg;

    tx_buf_if #(.W(34)) bif ();

    tx_skid_buf #(.W(34)) u_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(bif.buffer)
    );

    // address decode of the three access points
    always_comb begin
        hit_set = !reg_cfg_space && (reg_addr == `LEC_OFS_SET);
        hit_clr = !reg_cfg_space && (reg_addr == `LEC_OFS_CLR);
        hit_cfg = reg_cfg_space && (reg_addr == `LEC_OFS_CFG);
        wmask = reg_wdata & `LEC_WR_MASK;
    end

    // threshold in quadlets and the store-and-forward decision
    always_comb begin
        unique case (s_r.lec[`LEC_THR_HI:`LEC_THR_LO])
            `THR_SNF: thr_quads = `AT_QUAD_2K;
            `THR_1K7: thr_quads = `AT_QUAD_1K7;
            `THR_1K: thr_quads = `AT_QUAD_1K;
            `THR_512: thr_quads = `AT_QUAD_512;
        endcase
        snf = (s_r.lec[`LEC_THR_HI:`LEC_THR_LO] == `THR_SNF)
            || s_r.snf_retry
            || retry_count_zero;
        // complete packet always starts; threshold only when not snf
        start = (s_r.eop_pend != `EOP_ZERO)
            || (!snf && (s_r.fill >= thr_quads));
        can_req = !s_r.rd_wait && !s_r.rd_req && !s_r.push
            && bif.in_ready;
    end

    // next state of registers and transmit sequencing
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_req = 1'b0;
        s_nxt.push = 1'b0;
        s_nxt.underrun = 1'b0;
        // register writes; only global reset returns the fields to LEC_RESET
        if (reg_wr && hit_set) begin
            s_nxt.lec = s_r.lec | wmask;
        end else if (reg_wr && hit_clr) begin
            s_nxt.lec = s_r.lec & ~wmask;
        end else if (reg_wr && hit_cfg) begin
            s_nxt.lec = wmask;
        end
        // reads return the image with reserved bits at zero
        if (reg_rd) begin
            if (hit_set || hit_clr || hit_cfg) begin
                s_nxt.rdata = s_r.lec & `LEC_WR_MASK;
            end else begin
                s_nxt.rdata = `LEC_ZERO;
            end
        end
        s_nxt.mpeg_apply = s_r.lec[`LEC_MPEG_BIT]
            && (stream_format_code == `MPEG_FMT);
        // fifo fill count: quadlets checked in less quadlets requested
        s_nxt.fill = s_r.fill + (fifo_wr_quad ? `FILL_ONE : `FILL_ZERO);
        s_nxt.eop_pend = s_r.eop_pend
            + ((fifo_wr_quad && fifo_wr_eop) ? `EOP_ONE : `EOP_ZERO);
        if (fifo_rd_valid) begin
            s_nxt.rd_wait = 1'b0;
            if (fifo_rd_eop) begin
                s_nxt.eop_pend = s_nxt.eop_pend - `EOP_ONE;
            end
        end
        unique case (s_r.st)
            lec_pkg::TX_IDLE: begin
                if (start) begin
                    s_nxt.st = lec_pkg::TX_SEND;
                end
            end
            lec_pkg::TX_SEND: begin
                if (fifo_rd_valid) begin
                    s_nxt.push = 1'b1;
                    s_nxt.push_data = {1'b0, fifo_rd_eop, fifo_rd_data};
                    if (fifo_rd_eop) begin
                        s_nxt.st = lec_pkg::TX_IDLE;
                        s_nxt.snf_retry = 1'b0;
                    end
                end else if (can_req && (s_r.fill != `FILL_ZERO)) begin
                    s_nxt.rd_req = 1'b1;
                    s_nxt.rd_wait = 1'b1;
                    s_nxt.fill = s_nxt.fill - `FILL_ONE;
                end else if (can_req) begin
                    // fifo ran dry before the packet end: close with error
                    s_nxt.push = 1'b1;
                    s_nxt.push_data = {1'b1, 1'b1, `LEC_ZERO};
                    s_nxt.underrun = 1'b1;
                    s_nxt.snf_retry = 1'b1;
                    s_nxt.st = lec_pkg::TX_DRAIN;
                end
            end
            lec_pkg::TX_DRAIN: begin
                // discard the rest of the failed packet
                if (fifo_rd_valid && fifo_rd_eop) begin
                    s_nxt.st = lec_pkg::TX_IDLE;
                end else if (!s_r.rd_wait && !s_r.rd_req
                        && (s_r.fill != `FILL_ZERO)) begin
                    s_nxt.rd_req = 1'b1;
                    s_nxt.rd_wait = 1'b1;
                    s_nxt.fill = s_nxt.fill - `FILL_ONE;
                end
            end
        endcase
        // local reset drops transfer state but keeps the fields
        if (!soft_rst_n) begin
            s_nxt = '0;
            s_nxt.lec = s_r.lec;
            s_nxt.st = lec_pkg::TX_IDLE;
        end
    end

    // global reset clears everything but the fields, which load LEC_RESET
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.lec <= `LEC_RESET;
            s_r.st <= lec_pkg::TX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // buffer hookup and registered outputs
    assign bif.in_valid = s_r.push;
    assign bif.in_data = s_r.push_data;
    assign bif.out_ready = link_ready;
    assign link_valid = bif.out_valid;
    assign link_data = bif.out_data[31:0];
    assign link_eop = bif.out_data[32];
    assign link_err = bif.out_data[33];
    assign fifo_rd_req = s_r.rd_req;
    assign reg_rdata = s_r.rdata;
    assign at_underrun = s_r.underrun;
    assign async_tx_pipeline_disable = s_r.lec[`LEC_PIPE_BIT];
    assign mpeg_timestamp_enable = s_r.lec[`LEC_MPEG_BIT];
    assign mpeg_ts_apply = s_r.mpeg_apply;
endmodule : at_tx_ctrl

// File: tb/at_tx_ctrl_assertions.sv
/*
 * checker of the transmit start controller, on its top ports.
 * assumes one clock and the synchronous active-low global reset.
 */
`timescale 1ns/10ps
`include "lec_cfg.svh"
module at_tx_ctrl_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_cfg_space,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] stream_format_code,
    input wire logic fifo_rd_req,
    input wire logic link_valid,
    input wire logic link_ready,
    input wire logic [31:0] link_data,
    input wire logic link_eop,
    input wire logic link_err,
    input wire logic at_underrun,
    input wire logic async_tx_pipeline_disable,
    input wire logic mpeg_timestamp_enable,
    input wire logic mpeg_ts_apply
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // steps of a register write and of the read spacing
    sequence mem_wr(a);
        reg_wr && !reg_cfg_space && reg_addr == a;
    endsequence
    sequence quiet2;
        !fifo_rd_req ##1 !fifo_rd_req;
    endsequence
    pipe_set_a: assert property (mem_wr(`LEC_OFS_SET) ##0 reg_wdata[15]
        |-> ##[1:2] async_tx_pipeline_disable) else $error("pipe set");
    mpeg_clr_a: assert property (mem_wr(`LEC_OFS_CLR) ##0 reg_wdata[10]
        |-> ##[1:2] !mpeg_timestamp_enable) else $error("mpeg clear");
    rsvd_zero_a: assert property ((reg_rdata & ~`LEC_WR_MASK) == 32'h0)
        else $error("reserved bits set");
    ts_apply_a: assert property (mpeg_ts_apply
        |-> $past(stream_format_code) == `MPEG_FMT) else $error("ts apply");
    ts_off_a: assert property (!mpeg_timestamp_enable[*2]
        |-> !mpeg_ts_apply) else $error("ts apply off");
    rd_space_a: assert property (fifo_rd_req |=> quiet2)
        else $error("reads too close");
    err_word_a: assert property (link_valid && link_err
        |-> link_eop && link_data == 32'h0) else $error("error word");
    under_pulse_a: assert property (at_underrun |=> !at_underrun)
        else $error("underrun pulse");
    link_hold_a: assert property (link_valid && !link_ready |=> link_valid
        && $stable(link_data) && $stable({link_eop, link_err}))
        else $error("link word dropped");
endmodule : at_tx_ctrl_chk

bind at_tx_ctrl at_tx_ctrl_chk chk (.*);

// File: tb/at_fifo_model.sv
/*
 * transmit fifo model: answers a read one cycle later, data counts up.
 * assumes writes and reads on the rising edge of core_clk.
 */
`timescale 1ns/10ps
module at_fifo_model (
    input wire logic core_clk,
    input wire logic fifo_wr_quad,
    input wire logic fifo_wr_eop,
    input wire logic fifo_rd_req,
    output logic fifo_rd_valid,
    output logic [31:0] fifo_rd_data,
    output logic fifo_rd_eop
);
    logic eopq[$];
    logic [31:0] n = 32'h0;
    initial {fifo_rd_valid, fifo_rd_data, fifo_rd_eop} = 34'h0;
    // store token flags, answer reads, scramble lines between answers
    always @(posedge core_clk) begin
        if (fifo_wr_quad)
            eopq.push_back(fifo_wr_eop);
        fifo_rd_valid <= fifo_rd_req;
        if (fifo_rd_req && eopq.size() > 0) begin
            fifo_rd_data <= n;
            fifo_rd_eop <= eopq.pop_front();
            n <= n + 32'h1;
        end else begin
            fifo_rd_data <= ~fifo_rd_data;
            fifo_rd_eop <= ~fifo_rd_eop;
        end
    end
endmodule : at_fifo_model

// File: tb/test_async_transmit_threshold_control.sv
/*
 * testbench of the transmit start controller with a fifo model.
 * assumes the register offsets and masks of lec_cfg.svh.
 */
`timescale 1ns/10ps
`include "lec_cfg.svh"
module test_async_transmit_threshold_control;
    logic core_clk, rst_n, soft_rst_n, reg_cfg_space, reg_wr, reg_rd;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fifo_rd_data, link_data, d, r;
    logic [7:0] stream_format_code;
    logic retry_count_zero, fifo_wr_quad, fifo_wr_eop, fifo_rd_req;
    logic fifo_rd_valid, fifo_rd_eop, link_valid, link_eop, link_err;
    logic link_ready = 1'b0;
    logic at_underrun, async_tx_pipeline_disable;
    logic mpeg_timestamp_enable, mpeg_ts_apply;
    logic [33:0] expq[$];
    int mismatches = 0, num_checks = 0, words = 0, unders = 0;
    int nexp = 0, seed = 78, w0;
    at_tx_ctrl dut (.*);
    at_fifo_model fifo (.*);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: reg %h not %h", $time, got, exp);
        end
    endtask : cmp_reg
    task cmp_word(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask : cmp_word
    task idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle
    task wreg(input logic c, input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_cfg_space <= c;
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wreg
    task rreg(input logic c, input logic [11:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_cfg_space <= c;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask : rreg
    // write quadlets into the fifo, noting the words the link should see
    task push(input int n, input logic eop, input logic q);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            fifo_wr_quad <= 1'b1;
            fifo_wr_eop <= eop && i == n - 1;
            if (q)
                expq.push_back({32'(nexp), eop && i == n - 1, 1'b0});
            nexp++;
        end
        @(posedge core_clk);
        fifo_wr_quad <= 1'b0;
        fifo_wr_eop <= 1'b0;
    endtask : push
    // random link stalls; compare every accepted word with the oldest note
    always @(posedge core_clk) begin
        link_ready <= 1'($random(seed));
        if (at_underrun === 1'b1)
            unders++;
        if (link_valid === 1'b1 && link_ready === 1'b1) begin
            words++;
            cmp_word({link_data, link_eop, link_err}, expq.pop_front());
        end
    end
    initial begin
        #(20000 * 20);
        mismatches++;
        results;
    end
    // register checks, then start thresholds, underrun and fallback
    initial begin
        // global reset low, local reset released, no register strobe
        {rst_n, soft_rst_n, reg_cfg_space, reg_wr, reg_rd} = 5'h08;
        {reg_addr, reg_wdata, stream_format_code} = 52'h0;
        {retry_count_zero, fifo_wr_quad, fifo_wr_eop} = 3'h0;
        idle(5);
        rst_n <= 1'b1;
        rreg(0, `LEC_OFS_SET, d);
        cmp_reg(d, `LEC_RESET);
        wreg(0, `LEC_OFS_SET, 32'hffff_bfff);
        rreg(1, `LEC_OFS_CFG, d);
        cmp_reg(d, `LEC_WR_MASK);
        cmp_reg({30'h0, async_tx_pipeline_disable, mpeg_timestamp_enable},
            32'h3);
        stream_format_code <= `MPEG_FMT;
        idle(3);
        cmp_reg({31'h0, mpeg_ts_apply}, 32'h1);
        stream_format_code <= 8'h21;
        idle(3);
        cmp_reg({31'h0, mpeg_ts_apply}, 32'h0);
        soft_rst_n <= 1'b0;
        idle(2);
        soft_rst_n <= 1'b1;
        rreg(0, `LEC_OFS_SET, d);
        cmp_reg(d, `LEC_WR_MASK);
        wreg(0, `LEC_OFS_CLR, 32'h0000_8400);
        rreg(1, `LEC_OFS_CFG, d);
        cmp_reg(d, 32'h0000_3000);
        wreg(0, 12'h123, 32'hffff_ffff);
        rreg(0, 12'h123, d);
        cmp_reg(d, 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed) & 32'hffff_bfff;
            wreg(1, `LEC_OFS_CFG, r);
            rreg(1, `LEC_OFS_CFG, d);
            cmp_reg(d, r & `LEC_WR_MASK);
        end
        // short packets go out on their token under every code
        for (int c = 0; c < 4; c++) begin
            wreg(1, `LEC_OFS_CFG, 32'(c) << 12);
            push(3, 1, 1);
            idle(40);
            cmp_reg(32'(expq.size()), 32'h0);
        end
        // 512 byte level reached, then the fifo runs dry
        w0 = words;
        push(128, 0, 1);
        expq.push_back({32'h0, 2'h3});
        idle(20);
        cmp_reg(32'(words > w0), 32'h1);
        idle(600);
        cmp_reg(32'(unders), 32'h1);
        push(5, 1, 0);
        idle(30);
        cmp_reg(32'(expq.size()), 32'h0);
        // retry, cleared retry count, then 2K: wait for the token
        for (int k = 0; k < 3; k++) begin
            retry_count_zero <= k == 1;
            if (k == 2)
                wreg(1, `LEC_OFS_CFG, 32'h0);
            w0 = words;
            push(129, 0, 1);
            idle(300);
            cmp_reg(32'(words - w0), 32'h0);
            push(1, 1, 1);
            idle(600);
            cmp_reg(32'(expq.size()), 32'h0);
        end
        results;
    end
endmodule : test_async_transmit_threshold_control
